// *** verilog/cdm_params.svh ***
// timing constants and reset values for the clock divider and decode block
`ifndef CDM_PARAMS_SVH
`define CDM_PARAMS_SVH

// ----------------------------------------------------------------------
// oscillator and derived clocks
// ----------------------------------------------------------------------
`define CDM_OSC_FREQ_KHZ 23962
`define CDM_DIV_RESET 3'h0
`define CDM_DOT_RESET 1'h0

// ----------------------------------------------------------------------
// i/o wait chain
// ----------------------------------------------------------------------
`define CDM_WAIT_STAGES 4
`define CDM_WAIT_RESET 4'h0

`endif

// *** verilog/cdm_pkg.sv ***
// types shared by the clock divider and decode block
package cdm_pkg;
   typedef enum logic [2:0] {
      CDM_IO_IDLE = 3'b001,
      CDM_IO_OPEN = 3'b010,
      CDM_IO_HELD = 3'b100
   } cdm_io_state_e;
endpackage

// *** verilog/cdm_wait_chain.sv ***
// shift chain that times the i/o wait after an i/o request
`timescale 1ns/1ps
`include "cdm_params.svh"
module cdm_wait_chain #(
   parameter int STAGES = `CDM_WAIT_STAGES
) (
   // clocking
   input wire logic clk_sys,
   input wire logic rst,
   // phase enable and request
   input wire logic phase_tick,
   input wire logic io_active,
   // chain taps
   output logic [STAGES-1:0] taps
);
   // ----------------------------------------------------------------------
   // chain held clear until a request, then shifted ones at divided rate
   // ----------------------------------------------------------------------
   logic [STAGES-1:0] next_taps;
   assign next_taps = !io_active ? '0 :
      (phase_tick ? {taps[STAGES-2:0], 1'b1} : taps);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         taps <= '0;
      end else begin
         taps <= next_taps;
      end
   end
endmodule

// *** verilog/cdm_core.sv ***
// clock divider chain and memory / i/o decode for the processor board
`timescale 1ns/1ps
`include "cdm_params.svh"
module cdm_core #(
   parameter int WAIT_STAGES = `CDM_WAIT_STAGES
) (
   // oscillator and reset
   input wire logic clk_sys,
   input wire logic rst,
   // processor bus control
   input wire logic memory_request_n,
   input wire logic io_request_n,
   input wire logic refresh_cycle_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic m1_n,
   // address and bank enables
   input wire logic address_bit_15,
   input wire logic address_bit_14,
   input wire logic address_bit_13,
   input wire logic rom_bank_enable,
   input wire logic video_bank_enable,
   input wire logic ram_bank_enable,
   input wire logic rom_config_jumper,
   // derived clocks
   output logic phase_n,
   output logic cpu_clock,
   output logic dot_clock,
   output logic video_counter_clock,
   output logic font_write_timing_n,
   output logic separator_clock_n,
   // memory selects
   output logic rom_select_n,
   output logic scratchpad_select_n,
   output logic font_write_enable_n,
   output logic video_ram_request,
   output logic video_space_decode_n,
   // main memory board strobes
   output logic main_chip_enable_n,
   output logic main_ras_n,
   output logic main_cas_n,
   // i/o
   output logic io_chip_select_n,
   output logic io_decoder_enable,
   output logic io_wait_stretch
);
   // ----------------------------------------------------------------------
   // divide-by-six ring with lock-up clear
   // ----------------------------------------------------------------------
   logic [2:0] div_stage;
   logic [2:0] next_div_stage;
   logic div_lockup;
   logic div_prev;
   logic phase_tick;
   assign div_lockup = &div_stage;
   // six-state ring 000,001,101,100,110,010; 111 and 011 fall back to 000
   always_comb begin
      next_div_stage = `CDM_DIV_RESET;
      if (div_lockup) begin
         next_div_stage = `CDM_DIV_RESET;
      end else begin
         case (div_stage)
            3'h0: next_div_stage = 3'h1;
            3'h1: next_div_stage = 3'h5;
            3'h5: next_div_stage = 3'h4;
            3'h4: next_div_stage = 3'h6;
            3'h6: next_div_stage = 3'h2;
            3'h2: next_div_stage = 3'h0;
            default: next_div_stage = `CDM_DIV_RESET;
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_stage <= `CDM_DIV_RESET;
         div_prev <= 1'b0;
      end else begin
         div_stage <= next_div_stage;
         div_prev <= div_stage[2];
      end
   end
   assign phase_tick = div_stage[2] & ~div_prev;

   // ----------------------------------------------------------------------
   // derived clock outputs
   // ----------------------------------------------------------------------
   logic dot_ff;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dot_ff <= `CDM_DOT_RESET;
      end else begin
         dot_ff <= ~dot_ff;
      end
   end
   assign dot_clock = dot_ff;
   assign phase_n = ~div_stage[2];
   assign font_write_timing_n = phase_n;
   assign separator_clock_n = phase_n;
   assign cpu_clock = ~div_stage[2];
   assign video_counter_clock = clk_sys;

   // ----------------------------------------------------------------------
   // memory decode
   // ----------------------------------------------------------------------
   wire rom_hit;
   wire video_hit;
   assign rom_hit = rom_bank_enable & ~address_bit_15 & ~address_bit_14 &
      refresh_cycle_n & rom_config_jumper;
   assign rom_select_n = ~rom_hit;
   assign scratchpad_select_n = rom_select_n;
   assign font_write_enable_n = rom_select_n;
   assign video_hit = video_bank_enable & address_bit_15 & address_bit_14 &
      (address_bit_13 | refresh_cycle_n);
   assign video_ram_request = video_hit & ~memory_request_n;
   assign video_space_decode_n = ~video_hit;

   // ----------------------------------------------------------------------
   // main memory board strobes
   // ----------------------------------------------------------------------
   wire mem_cycle;
   wire refresh_strobe;
   logic cas_delay;
   assign mem_cycle = ~memory_request_n & ram_bank_enable & ~video_hit &
      ~rom_hit;
   assign refresh_strobe = ~memory_request_n & ~refresh_cycle_n;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cas_delay <= 1'b0;
      end else begin
         cas_delay <= mem_cycle & refresh_cycle_n & (~rd_n | ~wr_n | ~m1_n);
      end
   end
   // refresh is ras-only; access adds cas one oscillator cycle later
   assign main_chip_enable_n = ~(mem_cycle | refresh_strobe);
   assign main_ras_n = ~(mem_cycle | refresh_strobe);
   assign main_cas_n = ~(cas_delay & mem_cycle);

   // ----------------------------------------------------------------------
   // i/o chip select and stretch
   // ----------------------------------------------------------------------
   cdm_pkg::cdm_io_state_e io_state;
   cdm_pkg::cdm_io_state_e next_io_state;
   wire io_start;
   wire io_held;
   assign io_start = ~io_request_n & (~rd_n | ~wr_n);
   always_comb begin
      next_io_state = io_state;
      case (io_state)
         cdm_pkg::CDM_IO_IDLE: begin
            if (io_start) begin
               next_io_state = cdm_pkg::CDM_IO_OPEN;
            end
         end
         cdm_pkg::CDM_IO_OPEN, cdm_pkg::CDM_IO_HELD: begin
            if (io_request_n) begin
               next_io_state = cdm_pkg::CDM_IO_IDLE;
            end else begin
               next_io_state = cdm_pkg::CDM_IO_HELD;
            end
         end
         default: begin
            next_io_state = cdm_pkg::CDM_IO_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         io_state <= cdm_pkg::CDM_IO_IDLE;
      end else begin
         io_state <= next_io_state;
      end
   end
   assign io_held = (io_state != cdm_pkg::CDM_IO_IDLE) & ~io_request_n;
   assign io_chip_select_n = ~(io_start | io_held);
   assign io_decoder_enable = ~io_chip_select_n;

   // ----------------------------------------------------------------------
   // i/o wait timing chain
   // ----------------------------------------------------------------------
   logic [WAIT_STAGES-1:0] wait_taps;
   cdm_wait_chain #(
      .STAGES(WAIT_STAGES)
   ) u_wait (
      .clk_sys(clk_sys),
      .rst(rst),
      .phase_tick(phase_tick),
      .io_active(~io_chip_select_n & m1_n),
      .taps(wait_taps)
   );
   // wait held until the last stage fills
   assign io_wait_stretch = ~io_chip_select_n & m1_n &
      ~wait_taps[WAIT_STAGES-1];
endmodule

// *** test/cdm_cpu_model.sv ***
// processor bus model driving control and address levels
`timescale 1ns/1ps
module cdm_cpu_model (
   // clock
   input wire logic clk_sys,
   // bus levels
   output logic memory_request_n,
   output logic io_request_n,
   output logic refresh_cycle_n,
   output logic rd_n,
   output logic wr_n,
   output logic m1_n,
   output logic address_bit_15,
   output logic address_bit_14,
   output logic address_bit_13
);
   initial {memory_request_n, io_request_n, refresh_cycle_n, rd_n, wr_n,
      m1_n, address_bit_15, address_bit_14, address_bit_13} = 9'h1f8;
   // one bus state, applied on the falling edge
   task automatic drive(input logic [8:0] v);
      @(negedge clk_sys);
      {memory_request_n, io_request_n, refresh_cycle_n, rd_n, wr_n,
         m1_n, address_bit_15, address_bit_14, address_bit_13} = v;
   endtask
endmodule

// *** test/cdm_core_properties.sv ***
// checker for the clock divider and decode block
`timescale 1ns/1ps
module cdm_core_chk (
   input wire logic clk_sys, rst, memory_request_n, io_request_n,
   input wire logic refresh_cycle_n, rd_n, wr_n, address_bit_15,
   input wire logic address_bit_14, address_bit_13, rom_bank_enable,
   input wire logic video_bank_enable, rom_config_jumper, phase_n,
   input wire logic cpu_clock, dot_clock, font_write_timing_n,
   input wire logic rom_select_n, scratchpad_select_n, font_write_enable_n,
   input wire logic video_ram_request, video_space_decode_n,
   input wire logic io_chip_select_n, io_decoder_enable,
   input wire logic separator_clock_n, main_ras_n, main_chip_enable_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic rom_hit = rom_bank_enable & !address_bit_15 & !address_bit_14
      & refresh_cycle_n & rom_config_jumper;
   wire logic vid_hit = video_bank_enable & address_bit_15 & address_bit_14
      & (address_bit_13 | refresh_cycle_n);
   a_phase_high_three: assert property ($rose(phase_n) |-> phase_n[*3] ##1 !phase_n) else $error("phase high span");
   a_phase_copies: assert property (cpu_clock == phase_n && font_write_timing_n == phase_n) else $error("phase copies");
   a_dot_toggles: assert property (!$past(rst) |-> dot_clock != $past(dot_clock)) else $error("dot clock");
   a_rom_decode: assert property (rom_select_n == !rom_hit) else $error("rom select");
   a_rom_shared: assert property (scratchpad_select_n == rom_select_n && font_write_enable_n == rom_select_n) else $error("rom shares");
   a_video_request: assert property (video_ram_request == (vid_hit & !memory_request_n)) else $error("video request");
   a_video_decode: assert property (video_space_decode_n == !vid_hit) else $error("video decode");
   a_io_start: assert property (!io_request_n && !(rd_n && wr_n) |-> !io_chip_select_n) else $error("io start");
   a_io_stretch: assert property (!io_chip_select_n && !io_request_n |=> !io_request_n |-> !io_chip_select_n) else $error("io stretch");
   a_io_decoder: assert property (io_decoder_enable == !io_chip_select_n) else $error("io decoder");
   a_io_release: assert property (io_request_n |-> io_chip_select_n) else $error("io release");
   a_separator_copy: assert property (separator_clock_n == phase_n) else $error("separator clock");
   a_refresh_strobe: assert property (!memory_request_n && !refresh_cycle_n |-> !main_ras_n && !main_chip_enable_n) else $error("refresh strobe");
   c_rom: cover property (!rom_select_n);
   c_video: cover property (video_ram_request);
   c_io_held: cover property (!io_chip_select_n && rd_n && wr_n);
endmodule
bind cdm_core cdm_core_chk chk (.*);

// *** test/clock_divider_and_memory_decode_tb_top.sv ***
// self-checking bench for the clock divider and decode block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %b got %b", n, e, g); end end
module clock_divider_and_memory_decode_tb_top;
   logic clk_sys = 0, rst = 1, rom_bank_enable = 0, video_bank_enable = 0;
   logic ram_bank_enable = 0, rom_config_jumper = 1;
   wire logic memory_request_n, io_request_n, refresh_cycle_n, rd_n, wr_n;
   wire logic m1_n, address_bit_15, address_bit_14, address_bit_13;
   wire logic phase_n, cpu_clock, dot_clock, video_counter_clock;
   wire logic font_write_timing_n, rom_select_n, scratchpad_select_n;
   wire logic font_write_enable_n, video_ram_request, video_space_decode_n;
   wire logic io_chip_select_n, io_decoder_enable, io_wait_stretch;
   int mismatches = 0, n_checks = 0;
   cdm_cpu_model bus (.*);
   cdm_core dut (.*, .separator_clock_n(), .main_chip_enable_n(),
      .main_ras_n(), .main_cas_n());
   initial forever #4 clk_sys = ~clk_sys;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_clocks;
      int lo = 0, hi = 0;
      logic d;
      for (int k = 0; k < 12 && phase_n !== 1'b0; k++) @(negedge clk_sys);
      while (phase_n === 1'b0 && lo < 12) begin lo++; @(negedge clk_sys); end
      while (phase_n === 1'b1 && hi < 12) begin hi++; @(negedge clk_sys); end
      `CHK("phase low", 3, lo)
      `CHK("phase high", 3, hi)
      d = dot_clock;
      @(negedge clk_sys);
      `CHK("dot", ~d, dot_clock)
      `CHK("video clk", clk_sys, video_counter_clock)
      $display("test clocks done");
   endtask
   task automatic t_rom;
      logic e;
      for (int i = 0; i < 32; i++) begin
         bus.drive({2'b11, i[1], 3'h5, i[3], i[2], 1'b0});
         {rom_bank_enable, rom_config_jumper} = {i[4], i[0]};
         #2 e = !(i[4] & !i[3] & !i[2] & i[1] & i[0]);
         `CHK("rom", e, rom_select_n)
         `CHK("scratch", e, scratchpad_select_n)
         `CHK("font we", e, font_write_enable_n)
      end
      $display("test rom done");
   endtask
   task automatic t_video;
      logic h;
      for (int i = 0; i < 64; i++) begin
         bus.drive({i[0], 1'b1, i[1], 3'h7, i[4], i[3], i[2]});
         video_bank_enable = i[5];
         #2 h = i[5] & i[4] & i[3] & (i[2] | i[1]);
         `CHK("video_ram_request", h & !i[0], video_ram_request)
         `CHK("vram dec", !h, video_space_decode_n)
      end
      $display("test video done");
   endtask
   task automatic t_io;
      for (int k = 0; k < 2; k++) begin
         bus.drive({3'h5, k[0], ~k[0], 4'h8});
         #2 `CHK("cs start", 1'b0, io_chip_select_n)
         `CHK("dec en", 1'b1, io_decoder_enable)
         `CHK("wait on", 1'b1, io_wait_stretch)
         bus.drive(9'h178);
         #2 `CHK("cs held", 1'b0, io_chip_select_n)
         repeat (40) @(negedge clk_sys);
         `CHK("wait off", 1'b0, io_wait_stretch)
         bus.drive(9'h1f8);
         #2 `CHK("cs end", 1'b1, io_chip_select_n)
      end
      $display("test io done");
   endtask
   initial begin
      repeat (10) @(negedge clk_sys);
      rst = 0;
      t_clocks;
      t_rom;
      t_video;
      t_io;
      finish_test;
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      mismatches++;
      finish_test;
   end
endmodule
